// file: logic/ghm_pkg.sv
// Shared constants, types and helpers of the gyro health monitor and serial readout.
// Assumes a single 10 MHz core clock; every pin is synchronised before use.
`default_nettype none

package ghm_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int SETTLE_US = 1000;
   localparam int SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);

   // ==========================================================
   // Message framing
   localparam int MSG_BYTES = 6;
   localparam int MSG_BITS = MSG_BYTES * 8;
   localparam logic [5:0] MSG_BITS_CNT = 6'h30;

   // ==========================================================
   // Command byte fields
   localparam int CMD_FACTORY_BIT = 7;
   localparam int CMD_SELFTEST_BIT = 6;
   localparam int CMD_RANGE_SRC_BIT = 5;
   localparam int CMD_RANGE_HI = 4;
   localparam int CMD_RANGE_LO = 3;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // ==========================================================
   // Status byte fields
   localparam int STAT_FAIL_BIT = 7;
   localparam int STAT_BADCK_BIT = 4;
   localparam int STAT_SELFTEST_BIT = 3;

   // ==========================================================
   // Rate ranges and self-test offset
   localparam logic [1:0] RANGE_900 = 2'h0;
   localparam logic [1:0] RANGE_300 = 2'h1;
   localparam logic [1:0] RANGE_150 = 2'h2;
   localparam logic [1:0] RANGE_75 = 2'h3;
   localparam logic [1:0] RANGE_DEFAULT = RANGE_75;
   localparam int SELFTEST_DPS = 50;
   localparam int SF_75 = 96;
   localparam int SF_150 = 48;
   localparam int SF_300 = 24;
   localparam int SF_900 = 8;

   // ==========================================================
   // Temperature: input in quarter degrees, 2.75 counts per degree = 11/16 per quarter
   localparam logic [15:0] TEMP_ZERO_CODE = 16'h0200;
   localparam logic signed [19:0] TEMP_SLOPE_NUM = 20'sh0000b;
   localparam int TEMP_SLOPE_SHIFT = 4;

   // ==========================================================
   // Calibration memory
   localparam int CAL_WORDS = 16;
   localparam int CAL_IDX_W = 4;
   localparam logic [CAL_IDX_W-1:0] CAL_LAST = 4'hf;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      PH_CHECK = 3'b001,
      PH_SETTLE = 3'b010,
      PH_RUN = 3'b100
   } ghm_phase_e;

   typedef struct packed {
      logic sclk;
      logic ss_n;
      logic mosi;
      logic mode_sel;
      logic selftest_pin;
   } ghm_pins_s;

   localparam ghm_pins_s PINS_IDLE = '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0, mode_sel: 1'b0, selftest_pin: 1'b0};

   typedef struct packed {
      ghm_phase_e phase;
      logic [CAL_IDX_W-1:0] cal_idx;
      logic cal_fault;
      logic trim_fault;
      logic [15:0] settle_cnt;
      logic health;
      logic selftest;
      logic adc_en;
      logic [7:0] cmd;
      logic bad_ck;
      logic active;
      logic [5:0] bit_cnt;
      logic [MSG_BITS-1:0] tx;
      logic [MSG_BITS-1:0] rx;
      ghm_pins_s prev;
      logic miso;
      logic miso_oe;
   } ghm_top_s;

   localparam ghm_top_s TOP_RESET = '{phase: PH_CHECK, cal_idx: '0, cal_fault: 1'b0, trim_fault: 1'b0,
      settle_cnt: 16'h0000, health: 1'b0, selftest: 1'b0, adc_en: 1'b0, cmd: CMD_RESET, bad_ck: 1'b0,
      active: 1'b0, bit_cnt: 6'h00, tx: '0, rx: '0, prev: PINS_IDLE, miso: 1'b0, miso_oe: 1'b0};

   // ==========================================================
   // Helpers
   function automatic logic [7:0] checksum(input logic [39:0] b);
      logic [10:0] s;
      s = 11'(b[39:32]) + 11'(b[31:24]) + 11'(b[23:16]) + 11'(b[15:8]) + 11'(b[7:0]);
      return ~s[7:0];
   endfunction : checksum

   function automatic logic [15:0] selftest_offset(input logic [1:0] range);
      case (range)
         RANGE_900: return 16'(SELFTEST_DPS * SF_900);
         RANGE_300: return 16'(SELFTEST_DPS * SF_300);
         RANGE_150: return 16'(SELFTEST_DPS * SF_150);
         default: return 16'(SELFTEST_DPS * SF_75);
      endcase
   endfunction : selftest_offset

endpackage : ghm_pkg

`default_nettype wire

// file: logic/ghm_sync.sv
// Two-stage synchroniser for a bundle of pins.
// Assumes pins are asynchronous to clk; the reset value matches the pins' idle level.
`default_nettype none

module ghm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ghm_sync_s;

   ghm_sync_s st_reg;
   ghm_sync_s st_next;

   // ==========================================================
   // Stages
   always_comb begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg <= '{s1: RESET_VAL, s2: RESET_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;

endmodule : ghm_sync

`default_nettype wire

// file: logic/ghm_msg.sv
// Builds the outgoing status message and validates the incoming command message.
// Purely combinational; the caller registers what it needs.
`default_nettype none

module ghm_msg (
   input wire logic [7:0] status,
   input wire logic [15:0] rate,
   input wire logic [11:0] temp_q,
   input wire logic [47:0] rx,
   output logic [47:0] tx,
   output logic rx_ok
);

   logic signed [19:0] tq;
   logic [15:0] temp_code;
   logic [39:0] body;

   // ==========================================================
   // Temperature code, reported only over the serial link
   always_comb begin
      tq = {{8{temp_q[11]}}, temp_q};
      tq = 20'(tq * ghm_pkg::TEMP_SLOPE_NUM);
      temp_code = ghm_pkg::TEMP_ZERO_CODE + 16'(tq >>> ghm_pkg::TEMP_SLOPE_SHIFT);
   end

   // ==========================================================
   // Framing
   always_comb begin
      body = {status, rate, temp_code};
      tx = {body, ghm_pkg::checksum(body)};
      rx_ok = (rx[7:0] == ghm_pkg::checksum(rx[47:8]));
   end

endmodule : ghm_msg

`default_nettype wire

// file: logic/ghm_top.sv
// Health monitor and serial readout of a single-axis rate sensor.
// Assumes core-clock inputs from the sensing front end and asynchronous serial pins.
`default_nettype none

module ghm_top #(
   parameter int SETTLE_CYCLES = ghm_pkg::SETTLE_CYCLES,
   parameter logic [11:0] AGC_LOW = 12'h100,
   parameter logic [11:0] AGC_HIGH = 12'he00,
   parameter logic [11:0] QUAD_LIMIT = 12'h400
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic mode_sel,
   input wire logic selftest_pin,
   input wire logic [8:0] cal_word,
   input wire logic [7:0] dac_readback,
   input wire logic [11:0] agc_level,
   input wire logic demod_sat,
   input wire logic [11:0] quad_mag,
   input wire logic [15:0] rate_in,
   input wire logic [11:0] temp_q,
   output logic [ghm_pkg::CAL_IDX_W-1:0] cal_index,
   output logic health_ok,
   output logic adc_enable,
   output logic selftest_active,
   output logic spi_miso,
   output logic spi_miso_oe
);

   ghm_pkg::ghm_top_s st_reg;
   ghm_pkg::ghm_top_s st_next;
   ghm_pkg::ghm_pins_s pins;
   logic [47:0] msg_tx;
   logic msg_rx_ok;
   logic [7:0] status;
   logic [1:0] range;
   logic [16:0] rate_sum;
   logic [15:0] rate_word;
   logic agc_ok;
   logic quad_exc;
   logic ss_fall;
   logic ss_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic checks_ok;

   // ==========================================================
   // Pin synchronisers
   ghm_sync #(
      .W(5),
      .RESET_VAL(ghm_pkg::PINS_IDLE)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d({sclk, ss_n, mosi, mode_sel, selftest_pin}),
      .q(pins)
   );

   // ==========================================================
   // Message framing
   ghm_msg u_msg (
      .status(status),
      .rate(rate_word),
      .temp_q(temp_q),
      .rx(st_reg.rx),
      .tx(msg_tx),
      .rx_ok(msg_rx_ok)
   );

   // ==========================================================
   // Data path
   always_comb begin
      range = st_reg.cmd[ghm_pkg::CMD_RANGE_SRC_BIT] ?
         st_reg.cmd[ghm_pkg::CMD_RANGE_HI:ghm_pkg::CMD_RANGE_LO] : ghm_pkg::RANGE_DEFAULT;
      // Offset applies at the scale of the active range
      rate_sum = {rate_in[15], rate_in}
         + (st_reg.selftest ? {1'b0, ghm_pkg::selftest_offset(range)} : 17'h00000);
      // Clip rather than wrap so a high rate plus offset never flips sign
      rate_word = (rate_sum[16] != rate_sum[15]) ? 16'h7fff : rate_sum[15:0];
      status = 8'h00;
      status[ghm_pkg::STAT_FAIL_BIT] = ~st_reg.health;
      status[ghm_pkg::STAT_BADCK_BIT] = st_reg.bad_ck;
      status[ghm_pkg::STAT_SELFTEST_BIT] = st_reg.selftest;
      status[1:0] = range;
   end

   // ==========================================================
   // Monitor terms
   always_comb begin
      agc_ok = (agc_level >= AGC_LOW) && (agc_level <= AGC_HIGH);
      quad_exc = quad_mag > QUAD_LIMIT;
      // Rate clipping is deliberately absent here: range overflow is not a fault
      checks_ok = (st_reg.phase == ghm_pkg::PH_RUN) && !st_reg.cal_fault && !st_reg.trim_fault && agc_ok
         && !demod_sat && !quad_exc;
      ss_fall = st_reg.prev.ss_n && !pins.ss_n;
      ss_rise = !st_reg.prev.ss_n && pins.ss_n;
      sclk_rise = !st_reg.prev.sclk && pins.sclk;
      sclk_fall = st_reg.prev.sclk && !pins.sclk;
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.prev = pins;
      st_next.adc_en = pins.mode_sel;
      st_next.selftest = pins.mode_sel ? st_reg.cmd[ghm_pkg::CMD_SELFTEST_BIT] : pins.selftest_pin;
      st_next.health = checks_ok && !st_reg.selftest;

      case (st_reg.phase)
         ghm_pkg::PH_CHECK: begin
            if (^cal_word) begin
               st_next.cal_fault = 1'b1;
            end
            if (dac_readback != cal_word[7:0]) begin
               st_next.trim_fault = 1'b1;
            end
            st_next.cal_idx = st_reg.cal_idx + 1'b1;
            if (st_reg.cal_idx == ghm_pkg::CAL_LAST) begin
               st_next.phase = ghm_pkg::PH_SETTLE;
            end
         end
         ghm_pkg::PH_SETTLE: begin
            // Any drive-level excursion restarts the count so only a steady loop passes
            if (!agc_ok) begin
               st_next.settle_cnt = 16'h0000;
            end else if (st_reg.settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
               st_next.phase = ghm_pkg::PH_RUN;
            end else begin
               st_next.settle_cnt = st_reg.settle_cnt + 16'h0001;
            end
         end
         ghm_pkg::PH_RUN: begin
            st_next.phase = ghm_pkg::PH_RUN;
         end
         default: begin
            st_next.phase = ghm_pkg::PH_CHECK;
         end
      endcase

      // Serial slave; outside digital mode the link is ignored and the output released
      st_next.miso_oe = pins.mode_sel && !pins.ss_n;
      if (!pins.mode_sel) begin
         st_next.active = 1'b0;
      end else if (ss_fall) begin
         st_next.active = 1'b1;
         st_next.bit_cnt = 6'h00;
         st_next.tx = msg_tx;
         st_next.miso = msg_tx[47];
      end else if (ss_rise && st_reg.active) begin
         st_next.active = 1'b0;
         // Short or long frames are treated like a bad checksum
         if (st_reg.bit_cnt == ghm_pkg::MSG_BITS_CNT && msg_rx_ok) begin
            st_next.cmd = st_reg.rx[47:40];
            st_next.bad_ck = 1'b0;
         end else begin
            st_next.bad_ck = 1'b1;
         end
      end else if (st_reg.active && !pins.ss_n) begin
         if (sclk_rise) begin
            st_next.rx = {st_reg.rx[46:0], pins.mosi};
            if (st_reg.bit_cnt != 6'h3f) begin
               st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
            end
         end else if (sclk_fall) begin
            st_next.tx = {st_reg.tx[46:0], 1'b0};
            st_next.miso = st_reg.tx[46];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg <= ghm_pkg::TOP_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cal_index = st_reg.cal_idx;
   assign health_ok = st_reg.health;
   assign adc_enable = st_reg.adc_en;
   assign selftest_active = st_reg.selftest;
   assign spi_miso = st_reg.miso;
   assign spi_miso_oe = st_reg.miso_oe;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_health_good;
      (st_reg.phase == ghm_pkg::PH_RUN) && !st_reg.cal_fault && !st_reg.trim_fault && !st_reg.selftest
         && (agc_level >= AGC_LOW) && (agc_level <= AGC_HIGH) && !demod_sat && (quad_mag <= QUAD_LIMIT)
         |=> st_reg.health;
   endproperty
   a_health_good: assert property (p_health_good) else $error("health low with all checks passing");

   property p_parity;
      // Reset release edge still samples the reset phase, so the check waits for nrst
      nrst && (st_reg.phase == ghm_pkg::PH_CHECK) && (^cal_word) |=> st_reg.cal_fault ##1 !st_reg.health [*3];
   endproperty
   a_parity: assert property (p_parity) else $error("parity fault did not drop health");

   property p_trim;
      nrst && (st_reg.phase == ghm_pkg::PH_CHECK) && (dac_readback != cal_word[7:0])
         |=> st_reg.trim_fault ##1 !st_reg.health;
   endproperty
   a_trim: assert property (p_trim) else $error("trim mismatch did not drop health");

   property p_agc;
      (agc_level < AGC_LOW) || (agc_level > AGC_HIGH) |=> !st_reg.health;
   endproperty
   a_agc: assert property (p_agc) else $error("drive level excursion did not drop health");

   property p_startup;
      st_reg.phase != ghm_pkg::PH_RUN |-> !st_reg.health;
   endproperty
   a_startup: assert property (p_startup) else $error("health high before loops settled");

   property p_sat_quad;
      demod_sat || (quad_mag > QUAD_LIMIT) |=> !st_reg.health;
   endproperty
   a_sat_quad: assert property (p_sat_quad) else $error("saturation or quadrature did not drop health");

   property p_selftest;
      st_reg.selftest |=> !st_reg.health;
   endproperty
   a_selftest: assert property (p_selftest) else $error("health high in self-test");

   property p_load;
      pins.mode_sel && ss_fall |=> st_reg.active && st_reg.miso == st_reg.tx[47]
         && st_reg.tx[47] != $past(st_reg.health);
   endproperty
   a_load: assert property (p_load) else $error("reply not loaded at select fall");

   property p_accept;
      pins.mode_sel && ss_rise && st_reg.active && st_reg.bit_cnt == ghm_pkg::MSG_BITS_CNT && msg_rx_ok
         |=> st_reg.cmd == $past(st_reg.rx[47:40]) && !st_reg.bad_ck;
   endproperty
   a_accept: assert property (p_accept) else $error("valid command not taken");

   property p_reject;
      pins.mode_sel && ss_rise && st_reg.active && !msg_rx_ok |=> st_reg.bad_ck && $stable(st_reg.cmd);
   endproperty
   a_reject: assert property (p_reject) else $error("bad command not ignored and flagged");

   property p_oe;
      !pins.mode_sel |=> !st_reg.miso_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("serial output driven in analogue mode");

   property p_cv_run;
      st_reg.phase == ghm_pkg::PH_RUN && st_reg.health;
   endproperty
   c_cv_run: cover property (p_cv_run);

   property p_cv_accept;
      ss_rise && st_reg.active && msg_rx_ok && st_reg.bit_cnt == ghm_pkg::MSG_BITS_CNT;
   endproperty
   c_cv_accept: cover property (p_cv_accept);

   property p_cv_reject;
      ss_rise && st_reg.active && !msg_rx_ok;
   endproperty
   c_cv_reject: cover property (p_cv_reject);

   property p_cv_selftest;
      st_reg.selftest && pins.mode_sel;
   endproperty
   c_cv_selftest: cover property (p_cv_selftest);

   property p_cv_wide_range;
      st_reg.selftest && pins.mode_sel && (range == ghm_pkg::RANGE_900);
   endproperty
   c_cv_wide_range: cover property (p_cv_wide_range);

endmodule : ghm_top

`default_nettype wire

// file: logic/ghm_pkg_end_marker_unused.sv
// Intentionally empty companion file.
`default_nettype none
`default_nettype wire

// file: verification/ghm_host.sv
// Host-side serial master model for the gyro readout: frames one 48-bit exchange per call.
// Assumes the bench calls xfer hierarchically; pins are asynchronous to the core clock.
`default_nettype none

module ghm_host (
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // Idle pins
   // Clock stands still low between frames; select released high
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   // ==========================================================
   // Frame check byte: inverted low byte of the five-byte sum
   function automatic logic [7:0] cksum(input logic [39:0] b);
      logic [10:0] s;
      s = 11'(b[39:32]) + 11'(b[31:24]) + 11'(b[23:16]) + 11'(b[15:8]) + 11'(b[7:0]);
      return ~s[7:0];
   endfunction : cksum

   // ==========================================================
   // One exchange, MSB first, 800 ns clock; minimum select timings kept
   task automatic xfer(input logic [47:0] cmd, output logic [47:0] rsp);
      int i;
      #37; // Off the core clock's edges on purpose
      ss_n = 1'b0;
      #25000;
      for (i = 47; i >= 0; i--) begin
         mosi = cmd[i];
         #400;
         sclk = 1'b1;
         rsp[i] = miso_oe ? miso : 1'bx;
         #400;
         sclk = 1'b0;
      end
      // Released data line shows the inverse so a stale value cannot pass as good
      mosi = ~mosi;
      #5000;
      ss_n = 1'b1;
      #15000;
   endtask : xfer

endmodule : ghm_host

`default_nettype wire

// file: verification/ghm_top_bench.sv
// Self-checking bench for the health monitor and serial readout.
// Assumes ghm_host as the serial master and a shortened settle count.
`default_nettype none

module ghm_top_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // Stimulus and wiring
   localparam int SETTLE = 20;
   localparam int BOOT = 16 + SETTLE;
   typedef struct packed {
      logic [11:0] agc;
      logic sat;
      logic [11:0] quad;
      logic [15:0] rate;
      logic ok;
   } ghm_row_s;

   logic clk;
   logic nrst = 1'b0;
   logic mode_sel = 1'b0;
   logic selftest_pin = 1'b0;
   logic demod_sat = 1'b0;
   logic [11:0] agc_level = 12'h800;
   logic [11:0] quad_mag = 12'h000;
   logic [11:0] temp_q = 12'h064;
   logic [15:0] rate_in = 16'h0100;
   logic [7:0] trim_err = 8'h00;
   logic [8:0] cal_mem [16];
   logic sclk, ss_n, mosi;
   logic [3:0] cal_index;
   logic [8:0] cal_word;
   logic [7:0] dac_readback;
   logic health_ok, adc_enable, selftest_active, spi_miso, spi_miso_oe;
   int n_fail = 0;
   int check_count = 0;
   ghm_row_s rows [8] = '{
      '{12'h800, 1'b0, 12'h000, 16'h7fff, 1'b1}, '{12'h100, 1'b0, 12'h000, 16'h0000, 1'b1},
      '{12'h0ff, 1'b0, 12'h000, 16'h0000, 1'b0}, '{12'he00, 1'b0, 12'h000, 16'h0000, 1'b1},
      '{12'he01, 1'b0, 12'h000, 16'h0000, 1'b0}, '{12'h800, 1'b1, 12'h000, 16'h0000, 1'b0},
      '{12'h800, 1'b0, 12'h400, 16'h0000, 1'b1}, '{12'h800, 1'b0, 12'h401, 16'h0000, 1'b0}};

   // Calibration memory answers combinationally, as the real array would
   assign cal_word = cal_mem[cal_index];
   assign dac_readback = cal_word[7:0] ^ trim_err;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   ghm_top #(.SETTLE_CYCLES(SETTLE)) u_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .mode_sel(mode_sel), .selftest_pin(selftest_pin), .cal_word(cal_word), .dac_readback(dac_readback),
      .agc_level(agc_level), .demod_sat(demod_sat), .quad_mag(quad_mag), .rate_in(rate_in), .temp_q(temp_q),
      .cal_index(cal_index), .health_ok(health_ok), .adc_enable(adc_enable), .selftest_active(selftest_active),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

   ghm_host u_host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(spi_miso), .miso_oe(spi_miso_oe));

   // ==========================================================
   // Compare and report
   task automatic chk_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic final_report;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Power-up with an optional parity or trim fault planted
   task automatic boot(input int bad_word, input logic [7:0] terr, input logic exp);
      int i;
      logic [7:0] d;
      @(posedge clk);
      nrst <= 1'b0;
      trim_err <= terr;
      for (i = 0; i < 16; i++) begin
         d = 8'(i * 17);
         cal_mem[i] <= {(^d) ^ (i == bad_word), d};
      end
      repeat (10) @(posedge clk);
      #1;
      chk_bit("health in reset", 1'b0, health_ok);
      chk_bit("oe in reset", 1'b0, spi_miso_oe);
      chk_bit("selftest in reset", 1'b0, selftest_active);
      @(posedge clk);
      nrst <= 1'b1;
      repeat (BOOT - 2) @(posedge clk);
      #1;
      chk_bit("health while settling", 1'b0, health_ok);
      repeat (8) @(posedge clk);
      #1;
      chk_bit("health after startup", exp, health_ok);
   endtask : boot

   // One serial exchange; the reply is checked field by field
   task automatic frame(input logic [7:0] cmd, input logic bad, input logic [7:0] st, input logic [15:0] rate);
      logic [47:0] c, r;
      logic [39:0] e;
      c[47:8] = {cmd, 32'h0};
      c[7:0] = u_host.cksum(c[47:8]) ^ {7'h0, bad};
      u_host.xfer(c, r);
      e = {st, rate, 16'h0244};
      chk_val("status", 16'(st), 16'(r[47:40]));
      chk_val("rate", rate, r[39:24]);
      chk_val("temp", 16'h0244, r[23:8]);
      chk_val("check byte", 16'(u_host.cksum(e)), 16'(r[7:0]));
      $display("frame %h done", cmd);
   endtask : frame

   // ==========================================================
   // Main sequence
   initial begin
      int i;
      boot(-1, 8'h00, 1'b1);
      boot(5, 8'h00, 1'b0);
      boot(-1, 8'h10, 1'b0);
      boot(-1, 8'h00, 1'b1);
      $display("test startup done");
      @(posedge clk);
      selftest_pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk_bit("pin selftest", 1'b1, selftest_active);
      chk_bit("health in selftest", 1'b0, health_ok);
      chk_bit("adc off", 1'b0, adc_enable);
      @(posedge clk);
      selftest_pin <= 1'b0;
      mode_sel <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk_bit("selftest off", 1'b0, selftest_active);
      chk_bit("adc on", 1'b1, adc_enable);
      $display("test analogue selftest done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         agc_level <= rows[i].agc;
         demod_sat <= rows[i].sat;
         quad_mag <= rows[i].quad;
         rate_in <= rows[i].rate;
         repeat (3) @(posedge clk);
         #1;
         chk_bit("health row", rows[i].ok, health_ok);
      end
      @(posedge clk);
      agc_level <= 12'h800;
      demod_sat <= 1'b0;
      quad_mag <= 12'h000;
      rate_in <= 16'h0100;
      repeat (3) @(posedge clk);
      $display("test health table done");
      frame(8'h30, 1'b0, 8'h03, 16'h0100);
      frame(8'h70, 1'b0, 8'h02, 16'h0100);
      chk_bit("serial selftest", 1'b1, selftest_active);
      chk_bit("health in selftest", 1'b0, health_ok);
      frame(8'h00, 1'b1, 8'h8a, 16'h0a60);
      frame(8'h00, 1'b0, 8'h9a, 16'h0a60);
      chk_bit("selftest cleared", 1'b0, selftest_active);
      chk_bit("health after bad frame", 1'b1, health_ok);
      frame(8'h00, 1'b0, 8'h03, 16'h0100);
      // Self-test offset at the 300 and 900 range scales, then clipping at full scale
      frame(8'h68, 1'b0, 8'h03, 16'h0100);
      frame(8'h60, 1'b0, 8'h89, 16'h05b0);
      frame(8'h40, 1'b0, 8'h88, 16'h0290);
      @(posedge clk);
      rate_in <= 16'h7000;
      frame(8'h00, 1'b0, 8'h8b, 16'h7fff);
      chk_bit("selftest off again", 1'b0, selftest_active);
      $display("test serial done");
      final_report;
   end

   // Whole run is about 8000 cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      final_report;
   end

endmodule : ghm_top_bench

`default_nettype wire
